// File: hw/dcar_pkg.sv
// Constants and types shared by the channel address and count register set.
// Assumes one controller clock and an active-low asynchronous reset.
//
// Notes on behaviour
// RL1: Every channel keeps a 16-bit current address.
// RL2: Software clears byte pointer before 16-bit programming.
// RL3: First byte is bits 7-0, second 15-8.
// RL4: Offset 0x00 write sets base and current address.
// RL5: Address steps by one per transfer, mode-directed.
// RL6: Autoinitialize reloads current address from base.
// RL7: Base address is write-only, never read back.
// RL8: Scatter/gather puts reserve buffer into base address.
// RL9: Software programs wide channels with halved addresses.
// RL10: Current count holds length minus one, decrements.
// RL11: Terminal count when count wraps 0x0000 to 0xFFFF.
// RL12: Autoinitialize reloads current count from base count.
// RL13: Offset 0x01 write sets base and current count.
// RL14: Scatter/gather count holds remaining buffer bytes.
// RL15: Channels one to three count bytes.
// RL16: Channels five to seven count 16-bit words.
// RL17: Wide channels take autoinitialize from second controller.
// RL18: Scatter/gather address carry steps the low page.
// RL19: Wide channels output address shifted left, bit0 low.
// RL20: Byte pointer toggles on every byte access.

package dcar_pkg;

    localparam int CH_NUM = 8;
    localparam int CH_W = 3;
    localparam int REG_W = 16;
    localparam int BYTE_W = 8;

    // Register offsets within a channel.
    localparam logic OFF_ADDR = 1'h0;
    localparam logic OFF_COUNT = 1'h1;

    // Base memory word layout: count in the high half, address low.
    localparam int BASE_W = 2 * REG_W;
    localparam int BASE_CNT_LSB = REG_W;
    localparam logic [3:0] LANE_ADDR_LO = 4'h1;
    localparam logic [3:0] LANE_ADDR_HI = 4'h2;
    localparam logic [3:0] LANE_CNT_LO = 4'h4;
    localparam logic [3:0] LANE_CNT_HI = 4'h8;
    localparam logic [3:0] LANE_ALL = 4'hF;

    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
    localparam logic [BASE_W-1:0] BASE_RESET = 32'h0000_0000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [REG_W-1:0] CNT_LAST = 16'h0000;
    localparam logic [REG_W-1:0] ADDR_TOP = 16'hFFFF;
    localparam logic [REG_W-1:0] ADDR_BOTTOM = 16'h0000;
    localparam logic [REG_W-1:0] STEP_ONE = 16'h0001;

    // First channel that moves 16-bit words.
    localparam logic [CH_W-1:0] FIRST_WIDE_CH = 3'h5;

    typedef enum logic {
        BP_LOW = 1'b0,
        BP_HIGH = 1'b1
    } dcar_bp_t;

endpackage

// File: hw/dcar_base_mem.sv
// Small byte-writable memory holding base address and base count words.
// Assumes the caller arbitrates its single write port; read data is
// registered, so it appears one clock after the read address.

`timescale 1ns/10ps
`default_nettype none

module dcar_base_mem
    import dcar_pkg::*;
#(
    parameter int WIDTH = BASE_W,
    parameter int DEPTH = CH_NUM,
    parameter int AW = CH_W
) (
    input wire logic i_clk,                 // Controller clock
    input wire logic i_reset_n,             // Asynchronous reset, low
    input wire logic i_we,                  // Write strobe
    input wire logic [WIDTH/8-1:0] i_be,    // Byte lane enables
    input wire logic [AW-1:0] i_waddr,      // Write word index
    input wire logic [WIDTH-1:0] i_wdata,   // Write data
    input wire logic [AW-1:0] i_raddr,      // Read word index
    output logic [WIDTH-1:0] o_rdata        // Registered read data
);

    initial begin
        if (WIDTH % 8 != 0 || DEPTH > (1 << AW) || DEPTH < 1) begin
            $error("dcar_base_mem: unsupported width or depth");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Base registers carry no reset value; software programs them first.
    for (genvar b = 0; b < WIDTH / 8; b++) begin : g_lane
        always_ff @(posedge i_clk) begin
            if (i_we && i_be[b]) begin
                mem[i_waddr][b*8 +: 8] <= i_wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= BASE_RESET;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

`default_nettype wire

// File: hw/dcar_regs.sv
// Eight-channel current and base address/count registers with byte access.
// Assumes mode bits, scatter/gather state and transfer strobes come from
// neighbouring controller logic on the same clock; page registers are
// outside and follow the carry pulses.

`timescale 1ns/10ps
`default_nettype none

module dcar_regs
    import dcar_pkg::*;
(
    input wire logic i_clk,                     // Controller clock
    input wire logic i_reset_n,                 // Asynchronous reset, low
    input wire logic i_bp_clear,                // Byte pointer clear cmd
    input wire logic i_wr,                      // Byte write strobe
    input wire logic i_rd,                      // Byte read strobe
    input wire logic [CH_W-1:0] i_ch,           // Channel for access
    input wire logic i_off,                     // Register offset
    input wire logic [BYTE_W-1:0] i_wdata,      // Write byte
    output logic [BYTE_W-1:0] o_rdata,          // Read byte
    output logic o_rvalid,                      // Read byte valid pulse
    input wire logic [3:0] i_mode1_auto,        // Autoinit, channels 0-3
    input wire logic [3:0] i_mode2_auto,        // Autoinit, channels 4-7
    input wire logic [CH_NUM-1:0] i_mode_dec,   // Address decrement mode
    input wire logic [CH_NUM-1:0] i_sg_mode,    // Scatter/gather active
    input wire logic i_xfer,                    // One transfer done
    input wire logic [CH_W-1:0] i_xfer_ch,      // Channel of transfer
    input wire logic i_rsv_load,                // Reserve buffer load
    input wire logic [CH_W-1:0] i_rsv_ch,       // Reserve buffer channel
    input wire logic [REG_W-1:0] i_rsv_addr,    // Reserve buffer address
    input wire logic [REG_W-1:0] i_rsv_count,   // Reserve buffer count
    output logic o_xfer_valid,                  // Transfer address valid
    output logic [REG_W:0] o_xfer_addr,         // Byte address used
    output logic o_tc,                          // Terminal count pulse
    output logic [CH_W-1:0] o_tc_ch,            // Channel at terminal count
    output logic o_page_inc,                    // Low page carry up
    output logic o_page_dec                     // Low page borrow down
);

    function automatic logic is_wide(input logic [CH_W-1:0] ch);
        is_wide = (ch >= FIRST_WIDE_CH);
    endfunction

    // Byte pointer.
    dcar_bp_t bp_reg;
    dcar_bp_t bp_next;
    wire logic access = i_wr || i_rd;

    always_comb begin
        bp_next = bp_reg;
        if (i_bp_clear) begin
            bp_next = BP_LOW; // RL2
        end else if (access) begin
            bp_next = (bp_reg == BP_LOW) ? BP_HIGH : BP_LOW; // RL20
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bp_reg <= BP_LOW;
        end else begin
            bp_reg <= bp_next;
        end
    end

    // Autoinit enables per channel; wide channels use the second block.
    wire logic [CH_NUM-1:0] auto_en = {i_mode2_auto, i_mode1_auto}; // RL17

    // Transfer stage: the base word is read while the strobe is taken.
    logic s1_vld_reg;
    logic [CH_W-1:0] s1_ch_reg;
    logic [BASE_W-1:0] base_word;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_vld_reg <= 1'b0;
            s1_ch_reg <= '0;
        end else begin
            s1_vld_reg <= i_xfer;
            s1_ch_reg <= i_xfer_ch;
        end
    end

    wire logic [REG_W-1:0] base_addr = base_word[REG_W-1:0];
    wire logic [REG_W-1:0] base_cnt = base_word[BASE_CNT_LSB +: REG_W];

    // Base memory write port: bus bytes first, reserve buffer otherwise.
    // A reserve load colliding with a bus write is dropped by design.
    wire logic [3:0] bus_lane =
        (i_off == OFF_ADDR) ?
            ((bp_reg == BP_LOW) ? LANE_ADDR_LO : LANE_ADDR_HI) :
            ((bp_reg == BP_LOW) ? LANE_CNT_LO : LANE_CNT_HI);
    wire logic mem_we = i_wr || i_rsv_load;
    wire logic [3:0] mem_be = i_wr ? bus_lane : LANE_ALL; // RL3
    wire logic [CH_W-1:0] mem_waddr = i_wr ? i_ch : i_rsv_ch;
    wire logic [BASE_W-1:0] mem_wdata =
        i_wr ? {4{i_wdata}} : {i_rsv_count, i_rsv_addr}; // RL8

    // RL7: the base word has no path back to the read data.
    dcar_base_mem #(
        .WIDTH(BASE_W),
        .DEPTH(CH_NUM),
        .AW(CH_W)
    ) u_base (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_we(mem_we),
        .i_be(mem_be),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(i_xfer_ch),
        .o_rdata(base_word)
    );

    // Current address and count per channel.
    logic [REG_W-1:0] cur_addr_reg [CH_NUM];
    logic [REG_W-1:0] cur_cnt_reg [CH_NUM];

    wire logic [REG_W-1:0] s1_addr = cur_addr_reg[s1_ch_reg];
    wire logic [REG_W-1:0] s1_cnt = cur_cnt_reg[s1_ch_reg];
    wire logic s1_tc = s1_vld_reg && (s1_cnt == CNT_LAST); // RL11
    wire logic s1_sg = i_sg_mode[s1_ch_reg];
    wire logic s1_dec = i_mode_dec[s1_ch_reg];
    wire logic s1_reload = s1_tc && (auto_en[s1_ch_reg] || s1_sg);

    for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
        logic [REG_W-1:0] addr_next;
        logic [REG_W-1:0] cnt_next;
        wire logic hit = s1_vld_reg && (s1_ch_reg == CH_W'(c));
        wire logic wr_hit = i_wr && (i_ch == CH_W'(c));

        always_comb begin
            addr_next = cur_addr_reg[c];
            cnt_next = cur_cnt_reg[c];
            if (hit && s1_reload) begin
                addr_next = base_addr; // RL6
                cnt_next = base_cnt; // RL12
            end else if (hit) begin
                // One unit per strobe: bytes low, words high.
                cnt_next = cur_cnt_reg[c] - STEP_ONE; // RL10 RL15 RL16
                if (i_mode_dec[c]) begin
                    addr_next = cur_addr_reg[c] - STEP_ONE; // RL5
                end else begin
                    addr_next = cur_addr_reg[c] + STEP_ONE; // RL5
                end
            end
            // A bus byte lands after the step, so software wins.
            if (wr_hit && i_off == OFF_ADDR) begin
                if (bp_reg == BP_LOW) begin
                    addr_next[7:0] = i_wdata; // RL4
                end else begin
                    addr_next[15:8] = i_wdata; // RL4
                end
            end
            if (wr_hit && i_off == OFF_COUNT) begin
                if (bp_reg == BP_LOW) begin
                    cnt_next[7:0] = i_wdata; // RL13
                end else begin
                    cnt_next[15:8] = i_wdata; // RL13
                end
            end
        end

        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                cur_addr_reg[c] <= REG_RESET;
                cur_cnt_reg[c] <= REG_RESET;
            end else begin
                cur_addr_reg[c] <= addr_next; // RL1
                cur_cnt_reg[c] <= cnt_next; // RL14
            end
        end
    end

    // Read path returns only current values.
    wire logic [REG_W-1:0] rd_word =
        (i_off == OFF_ADDR) ? cur_addr_reg[i_ch] : cur_cnt_reg[i_ch]; // RL7
    wire logic [BYTE_W-1:0] rd_byte =
        (bp_reg == BP_LOW) ? rd_word[7:0] : rd_word[15:8]; // RL3

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= BYTE_RESET;
            o_rvalid <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rd_byte : o_rdata;
            o_rvalid <= i_rd;
        end
    end

    // Outgoing transfer address and events.
    wire logic s1_wide = is_wide(s1_ch_reg);
    wire logic [REG_W:0] byte_addr =
        s1_wide ? {s1_addr, 1'b0} : {1'b0, s1_addr}; // RL19
    wire logic s1_step = s1_vld_reg && !s1_reload && s1_sg;
    wire logic carry_up = s1_step && !s1_dec && (s1_addr == ADDR_TOP);
    wire logic carry_dn = s1_step && s1_dec && (s1_addr == ADDR_BOTTOM);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_xfer_valid <= 1'b0;
            o_xfer_addr <= '0;
            o_tc <= 1'b0;
            o_tc_ch <= '0;
            o_page_inc <= 1'b0;
            o_page_dec <= 1'b0;
        end else begin
            o_xfer_valid <= s1_vld_reg;
            o_xfer_addr <= s1_vld_reg ? byte_addr : o_xfer_addr;
            o_tc <= s1_tc; // RL11
            o_tc_ch <= s1_tc ? s1_ch_reg : o_tc_ch;
            o_page_inc <= carry_up; // RL18
            o_page_dec <= carry_dn; // RL18
        end
    end

    // Checks.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    wire logic s1_bus_hit = i_wr && (i_ch == s1_ch_reg);

    AST_BP_TOGGLE: assert property ( // RL20
        access && !i_bp_clear |=> bp_reg != $past(bp_reg))
        else $error("byte pointer did not toggle");

    AST_BP_CLEAR: assert property ( // RL2
        i_bp_clear |=> bp_reg == BP_LOW)
        else $error("byte pointer not cleared");

    AST_WR_ORDER: assert property ( // RL3
        i_bp_clear ##1 (i_wr && i_off == OFF_ADDR && !s1_vld_reg)
        ##1 (i_wr && i_off == OFF_ADDR && !s1_vld_reg
             && i_ch == $past(i_ch))
        |=> cur_addr_reg[$past(i_ch)] == {$past(i_wdata), $past(i_wdata, 2)})
        else $error("address bytes stored in wrong order");

    AST_RD_CUR: assert property ( // RL7
        i_rd && i_off == OFF_ADDR && bp_reg == BP_LOW
        |=> o_rvalid && o_rdata == $past(rd_word[7:0]))
        else $error("read did not return current address byte");

    AST_TC: assert property ( // RL11
        s1_vld_reg && s1_cnt == CNT_LAST |=> o_tc && o_tc_ch == $past(s1_ch_reg))
        else $error("terminal count missed");

    AST_NO_TC: assert property ( // RL11
        !s1_vld_reg |=> !o_tc)
        else $error("terminal count without transfer");

    AST_CNT_DEC: assert property ( // RL10
        s1_vld_reg && !s1_reload && !s1_bus_hit
        |=> cur_cnt_reg[$past(s1_ch_reg)] == $past(s1_cnt) - STEP_ONE)
        else $error("count did not decrement");

    AST_ADDR_STEP: assert property ( // RL5
        s1_vld_reg && !s1_reload && !s1_bus_hit && !s1_dec
        |=> cur_addr_reg[$past(s1_ch_reg)] == $past(s1_addr) + STEP_ONE)
        else $error("address did not increment");

    AST_RELOAD: assert property ( // RL12
        s1_tc && auto_en[s1_ch_reg] && !s1_bus_hit
        |=> cur_cnt_reg[$past(s1_ch_reg)] == $past(base_cnt)
            && cur_addr_reg[$past(s1_ch_reg)] == $past(base_addr))
        else $error("autoinitialize reload failed");

    AST_WIDE_ADDR: assert property ( // RL19
        s1_vld_reg && s1_wide |=> o_xfer_valid && !o_xfer_addr[0]
            && o_xfer_addr[REG_W:1] == $past(s1_addr))
        else $error("wide channel address not shifted");

    AST_PAGE_CARRY: assert property ( // RL18
        s1_step && !s1_dec && s1_addr == ADDR_TOP |=> o_page_inc && !o_page_dec)
        else $error("low page carry missed");

    COV_AUTO: cover property (s1_tc && auto_en[s1_ch_reg]);
    COV_SG_WRAP: cover property (carry_up ##1 1'b1);
    COV_WIDE_TC: cover property (s1_tc && s1_wide);
    COV_TWO_BYTES: cover property (i_bp_clear ##1 i_wr ##1 i_wr);

endmodule

`default_nettype wire

// File: bench/dcar_xfer_src.sv
// Model of the transfer side: completes one transfer on request and
// hands reserve buffers over. Assumes the register block samples on the
// rising edge; this model changes its outputs only at falling edges.

`timescale 1ns/10ps
`default_nettype none

module dcar_xfer_src
    import dcar_pkg::*;
(
    input wire logic i_clk,                 // Controller clock
    output logic o_xfer,                    // One transfer done
    output logic [CH_W-1:0] o_xfer_ch,      // Channel of transfer
    output logic o_rsv_load,                // Reserve buffer load
    output logic [CH_W-1:0] o_rsv_ch,       // Reserve buffer channel
    output logic [REG_W-1:0] o_rsv_addr,    // Reserve buffer address
    output logic [REG_W-1:0] o_rsv_count    // Reserve buffer count
);
    initial begin
        o_xfer = 1'b0;
        o_xfer_ch = 3'h0;
        o_rsv_load = 1'b0;
        o_rsv_ch = 3'h0;
        o_rsv_addr = 16'h0000;
        o_rsv_count = 16'h0000;
    end

    // A slow source idles gap cycles first. Released qualifiers flip, so
    // a block that samples them outside the strobe sees wrong values.
    task automatic issue(input logic [CH_W-1:0] ch, input int gap);
        repeat (gap) @(negedge i_clk);
        @(negedge i_clk);
        o_xfer = 1'b1;
        o_xfer_ch = ch;
        @(negedge i_clk);
        o_xfer = 1'b0;
        o_xfer_ch = ~ch;
    endtask

    task automatic reserve(input logic [CH_W-1:0] ch,
                           input logic [REG_W-1:0] a,
                           input logic [REG_W-1:0] c);
        @(negedge i_clk);
        o_rsv_load = 1'b1;
        o_rsv_ch = ch;
        o_rsv_addr = a;
        o_rsv_count = c;
        @(negedge i_clk);
        o_rsv_load = 1'b0;
        o_rsv_addr = ~a;
        o_rsv_count = ~c;
    endtask
endmodule

`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the channel register set: byte-wise register
// access after a pointer clear, transfer stepping, terminal count,
// reloads and page carries. Assumes the transfer model drives i_xfer.

`timescale 1ns/10ps
`default_nettype none

module testbench;
    import dcar_pkg::*;
    logic i_clk, i_reset_n, i_bp_clear, i_wr, i_rd, i_off;
    logic i_xfer, i_rsv_load, o_rvalid, o_xfer_valid, o_tc;
    logic o_page_inc, o_page_dec;
    logic [CH_W-1:0] i_ch, i_xfer_ch, i_rsv_ch, o_tc_ch;
    logic [7:0] i_wdata, o_rdata, i_mode_dec, i_sg_mode;
    logic [3:0] i_mode1_auto, i_mode2_auto;
    logic [15:0] i_rsv_addr, i_rsv_count;
    logic [16:0] o_xfer_addr;
    int n_mismatch = 0;
    int samples_checked = 0;

    dcar_regs dut (.i_clk, .i_reset_n, .i_bp_clear, .i_wr, .i_rd, .i_ch,
        .i_off, .i_wdata, .o_rdata, .o_rvalid, .i_mode1_auto, .i_mode2_auto,
        .i_mode_dec, .i_sg_mode, .i_xfer, .i_xfer_ch, .i_rsv_load, .i_rsv_ch,
        .i_rsv_addr, .i_rsv_count, .o_xfer_valid, .o_xfer_addr, .o_tc,
        .o_tc_ch, .o_page_inc, .o_page_dec);

    dcar_xfer_src src (.i_clk(i_clk), .o_xfer(i_xfer), .o_xfer_ch(i_xfer_ch),
        .o_rsv_load(i_rsv_load), .o_rsv_ch(i_rsv_ch),
        .o_rsv_addr(i_rsv_addr), .o_rsv_count(i_rsv_count));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [16:0] got, input logic [16:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr16(input logic [2:0] c, input logic o,
                        input logic [15:0] v);
        @(negedge i_clk);
        i_bp_clear = 1'b1;
        @(negedge i_clk);
        i_bp_clear = 1'b0;
        i_wr = 1'b1;
        i_ch = c;
        i_off = o;
        i_wdata = v[7:0];
        @(negedge i_clk);
        i_wdata = v[15:8];
        @(negedge i_clk);
        i_wr = 1'b0;
        i_wdata = ~v[15:8];
    endtask

    // Two back-to-back reads; each byte shows one cycle after its strobe.
    task automatic rd16(input logic [2:0] c, input logic o,
                        input logic [15:0] exp, input string what);
        logic [15:0] got;
        logic v;
        @(negedge i_clk);
        i_bp_clear = 1'b1;
        @(negedge i_clk);
        i_bp_clear = 1'b0;
        i_rd = 1'b1;
        i_ch = c;
        i_off = o;
        @(negedge i_clk);
        got[7:0] = o_rdata;
        v = o_rvalid;
        @(negedge i_clk);
        i_rd = 1'b0;
        got[15:8] = o_rdata;
        chk({v & o_rvalid, got}, {1'b1, exp}, what);
    endtask

    // Results stand for one cycle, two edges after the transfer is taken.
    task automatic step(input logic [2:0] c, input int gap,
                        input logic [16:0] ea, input logic [2:0] ev);
        src.issue(c, gap);
        @(negedge i_clk);
        chk({o_xfer_valid, o_xfer_addr}, {1'b1, ea}, "xfer address");
        chk({11'h0, o_tc, o_page_inc, o_page_dec, o_tc ? o_tc_ch : c},
            {11'h0, ev, c}, "tc and carry");
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        $display("BAD t=%0t run timed out", $time);
        summarize();
    end

    initial begin
        {i_bp_clear, i_wr, i_rd, i_off, i_ch, i_wdata} = '0;
        {i_mode1_auto, i_mode2_auto, i_mode_dec, i_sg_mode} = '0;
        i_reset_n = 1'b0;
        repeat (3) @(negedge i_clk);
        i_reset_n = 1'b1;
        wr16(3'h2, 1'b0, 16'h1234);
        wr16(3'h2, 1'b1, 16'h0002);
        rd16(3'h2, 1'b0, 16'h1234, "ch2 address");
        rd16(3'h2, 1'b1, 16'h0002, "ch2 count");
        $display("test byte access done");
        i_mode1_auto = 4'h2;
        wr16(3'h1, 1'b0, 16'h00FF);
        wr16(3'h1, 1'b1, 16'h0001);
        step(3'h1, 0, 17'h000FF, 3'b000);
        step(3'h1, 3, 17'h00100, 3'b100);
        rd16(3'h1, 1'b0, 16'h00FF, "reloaded address");
        rd16(3'h1, 1'b1, 16'h0001, "reloaded count");
        $display("test autoinit done");
        i_mode_dec = 8'h08;
        wr16(3'h3, 1'b0, 16'h0010);
        wr16(3'h3, 1'b1, 16'h0000);
        step(3'h3, 0, 17'h00010, 3'b100);
        rd16(3'h3, 1'b1, 16'hFFFF, "wrapped count");
        rd16(3'h3, 1'b0, 16'h000F, "decremented address");
        rd16(3'h3, 1'b0, 16'h000F, "base not readable");
        $display("test decrement done");
        i_mode1_auto = 4'h0;
        i_mode2_auto = 4'h2;
        wr16(3'h5, 1'b0, 16'h00FF);
        wr16(3'h5, 1'b1, 16'h0000);
        step(3'h5, 0, 17'h001FE, 3'b100);
        rd16(3'h5, 1'b0, 16'h00FF, "wide reload");
        $display("test wide channel done");
        i_mode2_auto = 4'h0;
        i_sg_mode = 8'h40;
        wr16(3'h6, 1'b0, 16'hFFFF);
        wr16(3'h6, 1'b1, 16'h0001);
        src.reserve(3'h6, 16'h4000, 16'h0010);
        step(3'h6, 0, 17'h1FFFE, 3'b010);
        step(3'h6, 2, 17'h00000, 3'b100);
        rd16(3'h6, 1'b0, 16'h4000, "reserve address");
        rd16(3'h6, 1'b1, 16'h0010, "reserve count");
        i_sg_mode = 8'h44;
        i_mode_dec = 8'h0C;
        wr16(3'h2, 1'b0, 16'h0000);
        wr16(3'h2, 1'b1, 16'h0005);
        step(3'h2, 0, 17'h00000, 3'b001);
        $display("test scatter gather done");
        summarize();
    end
endmodule

`default_nettype wire
